// ===== rtl/dcsf_pkg.sv
// Shared constants and types for the dual-strobe FIFO with offset registers.
package dcsf_pkg;
    localparam int DATA_W = 18;
    localparam int OFS_W = 12;
    localparam int DEF_MEM_DEPTH = 256;
    localparam logic [11:0] DEF_OFFSET = 12'h01f;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] STRAP_FALL_THROUGH = 3'h1;
    localparam logic [1:0] FT_STAGE_EDGES = 2'h2;
    localparam logic [17:0] OUT_RESET = 18'h00000;
    localparam logic FULL_RESET_N = 1'b1;
    localparam logic HALF_RESET_N = 1'b1;
    localparam logic AFULL_RESET_N = 1'b1;
    localparam logic AEMPTY_RESET_N = 1'b0;
    localparam logic EMPTY_RESET_STD_N = 1'b0;
    localparam logic EMPTY_RESET_FT_N = 1'b1;

    typedef enum logic [1:0] {
        DCSF_OFS_EMPTY = 2'b01,
        DCSF_OFS_FULL = 2'b10
    } dcsf_ofs_sel_type;
endpackage

// ===== rtl/dcsf_store.sv
// Parameterised word store with valid/ready on both sides and registered read data.
`timescale 1ns/1ps
`default_nettype none
module dcsf_store #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rstn,
    // Filling side.
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Draining side.
    input wire logic i_out_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    // Fill level.
    output logic [CNT_W-1:0] o_count
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic [WIDTH-1:0] data_r;
    logic push;
    logic pop;

    assign o_in_ready = (count_r != CNT_W'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data = data_r;
    assign o_count = count_r;
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    // The popped word lands in the read register on the pop edge.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            data_r <= '0;
        end else if (pop) begin
            data_r <= mem_r[rd_ptr_r];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule
`default_nettype wire

// ===== rtl/dcsf_top.sv
// Strobe-driven FIFO with standard and fall-through modes and two offset registers.
`timescale 1ns/1ps
`default_nettype none
module dcsf_top
    import dcsf_pkg::*;
#(
    parameter int MEM_DEPTH = dcsf_pkg::DEF_MEM_DEPTH,
    parameter logic [11:0] OFFSET_DEFAULT = dcsf_pkg::DEF_OFFSET
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Write port pins.
    input wire logic i_write_strobe,
    input wire logic i_write_en_n,
    input wire logic [dcsf_pkg::DATA_W-1:0] i_write_data,
    // Read port pins.
    input wire logic i_read_strobe,
    input wire logic i_read_en_n,
    input wire logic i_out_en_n,
    // Offset load and configuration straps.
    input wire logic i_offset_load_n,
    input wire logic i_first_load_n,
    input wire logic i_read_chain_in,
    input wire logic i_write_chain_in,
    // Data outputs.
    output logic [dcsf_pkg::DATA_W-1:0] o_read_data,
    output logic o_read_data_oe,
    // Flags.
    output logic o_full_flag_n,
    output logic o_empty_flag_n,
    output logic o_half_full_n,
    output logic o_almost_full_n,
    output logic o_almost_empty_n,
    output logic o_fall_through_mode
);
    import dcsf_pkg::*;

    localparam int CNT_W = $clog2(MEM_DEPTH + 2);
    localparam int SCNT_W = $clog2(MEM_DEPTH + 1);
    localparam int PIN_W = DATA_W + 9;
    // Threshold sums are formed wide enough that a large offset cannot wrap.
    localparam int FLG_W = ((CNT_W > OFS_W) ? CNT_W : OFS_W) + 1;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic wr_strobe_d_r;
    logic rd_strobe_d_r;
    logic [DATA_W-1:0] wdata_s;
    logic wr_strobe_s;
    logic wen_n_s;
    logic rd_strobe_s;
    logic ren_n_s;
    logic oe_n_s;
    logic ld_n_s;
    logic fl_n_s;
    logic rxi_s;
    logic wxi_s;

    always_ff @(posedge i_ref_clk) begin
        pin_meta_r <= {i_write_data, i_write_strobe, i_write_en_n, i_read_strobe,
                       i_read_en_n, i_out_en_n, i_offset_load_n, i_first_load_n,
                       i_read_chain_in, i_write_chain_in};
        pin_sync_r <= pin_meta_r;
    end

    assign {wdata_s, wr_strobe_s, wen_n_s, rd_strobe_s, ren_n_s, oe_n_s, ld_n_s,
            fl_n_s, rxi_s, wxi_s} = pin_sync_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            wr_strobe_d_r <= 1'b0;
            rd_strobe_d_r <= 1'b0;
        end else begin
            wr_strobe_d_r <= wr_strobe_s;
            rd_strobe_d_r <= rd_strobe_s;
        end
    end

    logic wr_edge;
    logic rd_edge;
    assign wr_edge = wr_strobe_s && !wr_strobe_d_r;
    assign rd_edge = rd_strobe_s && !rd_strobe_d_r;

    // ------------------------------------------------------------------
    // Mode straps
    // ------------------------------------------------------------------
    logic ft_mode_r;

    // Straps are caught while reset is held, never by the reset itself.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ft_mode_r <= ({fl_n_s, rxi_s, wxi_s} == STRAP_FALL_THROUGH);
        end
    end

    // ------------------------------------------------------------------
    // Word store
    // ------------------------------------------------------------------
    logic st_in_ready;
    logic st_out_valid;
    logic [DATA_W-1:0] st_out_data;
    logic [SCNT_W-1:0] st_count;
    logic push;
    logic pop;

    // Only wen_n low, ld_n high and a not-full store let a write edge push a word.
    assign push = wr_edge && !wen_n_s && ld_n_s && st_in_ready;

    dcsf_store #(
        .WIDTH(DATA_W),
        .DEPTH(MEM_DEPTH),
        .CNT_W(SCNT_W)
    ) u_store (
        .i_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_in_valid(push),
        .o_in_ready(st_in_ready),
        .i_in_data(wdata_s),
        .i_out_ready(pop),
        .o_out_valid(st_out_valid),
        .o_out_data(st_out_data),
        .o_count(st_count)
    );

    // ------------------------------------------------------------------
    // Read control and output register
    // ------------------------------------------------------------------
    logic out_valid_r;
    logic load_pend_r;
    logic [1:0] stage_cnt_r;
    logic [DATA_W-1:0] out_r;
    logic std_read;
    logic ft_read;
    logic ft_fill;
    logic ofs_read;
    dcsf_ofs_sel_type ofs_wsel_r;
    dcsf_ofs_sel_type ofs_rsel_r;
    logic [OFS_W-1:0] empty_threshold_offset_r;
    logic [OFS_W-1:0] full_threshold_offset_r;

    // A standard read needs a request and a non-empty store.
    assign std_read = !ft_mode_r && rd_edge && !ren_n_s && ld_n_s && st_out_valid;
    // A fall-through read replaces the shown word when a further one is stored.
    assign ft_read = ft_mode_r && rd_edge && !ren_n_s && ld_n_s && out_valid_r;
    // An empty output register fills on the third read edge, after two staging ones.
    assign ft_fill = ft_mode_r && rd_edge && !out_valid_r && !load_pend_r && st_out_valid &&
                     (stage_cnt_r == FT_STAGE_EDGES);
    assign pop = std_read || (ft_read && st_out_valid) || ft_fill;
    assign ofs_read = !ft_mode_r && rd_edge && !ren_n_s && !ld_n_s;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            stage_cnt_r <= '0;
        end else if (out_valid_r || load_pend_r || !st_out_valid) begin
            stage_cnt_r <= '0;
        end else if (rd_edge && stage_cnt_r != FT_STAGE_EDGES) begin
            stage_cnt_r <= stage_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            load_pend_r <= 1'b0;
        end else begin
            load_pend_r <= pop;
        end
    end

    // The store's read register holds the popped word one cycle later.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            out_r <= OUT_RESET;
        end else if (load_pend_r) begin
            out_r <= st_out_data;
        end else if (ofs_read) begin
            if (ofs_rsel_r == DCSF_OFS_EMPTY) begin
                out_r <= {{(DATA_W - OFS_W){1'b0}}, empty_threshold_offset_r};
            end else begin
                out_r <= {{(DATA_W - OFS_W){1'b0}}, full_threshold_offset_r};
            end
        end
    end

    // Fall-through holds the last word after a drain; the valid bit drives ready.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            out_valid_r <= 1'b0;
        end else if (load_pend_r && ft_mode_r) begin
            out_valid_r <= 1'b1;
        end else if (ft_read && !st_out_valid) begin
            out_valid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Offset registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            empty_threshold_offset_r <= OFFSET_DEFAULT;
            full_threshold_offset_r <= OFFSET_DEFAULT;
            ofs_wsel_r <= DCSF_OFS_EMPTY;
        end else if (wr_edge && !ld_n_s && !wen_n_s) begin
            case (ofs_wsel_r)
                DCSF_OFS_EMPTY: begin
                    empty_threshold_offset_r <= wdata_s[OFS_W-1:0];
                    ofs_wsel_r <= DCSF_OFS_FULL;
                end
                DCSF_OFS_FULL: begin
                    full_threshold_offset_r <= wdata_s[OFS_W-1:0];
                    ofs_wsel_r <= DCSF_OFS_EMPTY;
                end
                default: begin
                    ofs_wsel_r <= DCSF_OFS_EMPTY;
                end
            endcase
        end
    end

    // The read selector is separate and, like the write one, survives ld_n high.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ofs_rsel_r <= DCSF_OFS_EMPTY;
        end else if (ofs_read) begin
            case (ofs_rsel_r)
                DCSF_OFS_EMPTY: ofs_rsel_r <= DCSF_OFS_FULL;
                DCSF_OFS_FULL: ofs_rsel_r <= DCSF_OFS_EMPTY;
                default: ofs_rsel_r <= DCSF_OFS_EMPTY;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // Both sides share one clock, so counts are compared without any crossing.
    logic [CNT_W-1:0] words;
    logic [CNT_W-1:0] capacity;
    logic [SCNT_W-1:0] st_count_after_pop;
    assign words = CNT_W'(st_count) + CNT_W'(out_valid_r || load_pend_r && ft_mode_r);
    assign capacity = CNT_W'(MEM_DEPTH) + CNT_W'(ft_mode_r);
    assign st_count_after_pop = st_count - SCNT_W'(pop);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_full_flag_n <= FULL_RESET_N;
        end else if (wr_edge) begin
            // Full is judged after this edge's push, on write edges only.
            if (ft_mode_r) begin
                o_full_flag_n <= (words + CNT_W'(push) == capacity);
            end else begin
                o_full_flag_n <= (words + CNT_W'(push) != capacity);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_empty_flag_n <= ft_mode_r ? EMPTY_RESET_FT_N : EMPTY_RESET_STD_N;
        end else if (ft_mode_r) begin
            o_empty_flag_n <= !out_valid_r;
        end else if (rd_edge) begin
            o_empty_flag_n <= (st_count_after_pop != '0);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_half_full_n <= HALF_RESET_N;
            o_almost_full_n <= AFULL_RESET_N;
            o_almost_empty_n <= AEMPTY_RESET_N;
        end else begin
            o_half_full_n <= (words <= CNT_W'(MEM_DEPTH / 2) + CNT_W'(ft_mode_r));
            o_almost_full_n <= (FLG_W'(words) + FLG_W'(full_threshold_offset_r) <
                                FLG_W'(capacity));
            o_almost_empty_n <= (FLG_W'(words) >
                                 FLG_W'(empty_threshold_offset_r) + FLG_W'(ft_mode_r));
        end
    end

    // ------------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_read_data <= OUT_RESET;
            o_read_data_oe <= 1'b0;
            o_fall_through_mode <= 1'b0;
        end else begin
            o_read_data <= out_r;
            o_read_data_oe <= !oe_n_s;
            o_fall_through_mode <= ft_mode_r;
        end
    end
endmodule
`default_nettype wire

// ===== tb/dcsf_top_monitor.sv
// Concurrent checks on the FIFO top ports, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module dcsf_top_monitor
    import dcsf_pkg::*;
#(
    parameter int MEM_DEPTH = 8,
    parameter logic [11:0] OFFSET_DEFAULT = 12'h01f
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_write_en_n,
    input wire logic i_read_en_n,
    input wire logic i_out_en_n,
    input wire logic i_offset_load_n,
    input wire logic i_first_load_n,
    input wire logic i_read_chain_in,
    input wire logic i_write_chain_in,
    input wire logic [dcsf_pkg::DATA_W-1:0] o_read_data,
    input wire logic o_read_data_oe,
    input wire logic o_full_flag_n,
    input wire logic o_empty_flag_n,
    input wire logic o_half_full_n,
    input wire logic o_almost_full_n,
    input wire logic o_almost_empty_n,
    input wire logic o_fall_through_mode
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // Cycles since reset release and since the last enabled write or read, saturating.
    logic [4:0] rst_age_r, wen_age_r, ren_age_r;
    always_ff @(posedge i_ref_clk) begin
        rst_age_r <= !i_rstn ? 5'h00 : rst_age_r + {4'h0, rst_age_r != 5'h1f};
    end
    always_ff @(posedge i_ref_clk) begin
        wen_age_r <= !i_rstn ? 5'h1f : !i_write_en_n ? 5'h00 : wen_age_r + {4'h0, wen_age_r != 5'h1f};
    end
    always_ff @(posedge i_ref_clk) begin
        ren_age_r <= !i_rstn ? 5'h1f : !i_read_en_n ? 5'h00 : ren_age_r + {4'h0, ren_age_r != 5'h1f};
    end
    reset_vals_a: assert property ($rose(i_rstn) |-> o_full_flag_n && o_half_full_n
        && o_almost_full_n && !o_almost_empty_n && o_read_data == OUT_RESET && o_empty_flag_n ==
        ({i_first_load_n, i_read_chain_in, i_write_chain_in} == STRAP_FALL_THROUGH))
        else $error("reset values wrong");
    mode_strap_a: assert property ($rose(i_rstn) |-> ##2 o_fall_through_mode ==
        ({i_first_load_n, i_read_chain_in, i_write_chain_in} == STRAP_FALL_THROUGH))
        else $error("mode not taken from straps");
    mode_stable_a: assert property (rst_age_r > 5'd3 |-> $stable(o_fall_through_mode))
        else $error("mode changed outside reset");
    oe_follow_a: assert property ($changed(i_out_en_n) |-> ##[1:3] o_read_data_oe == !i_out_en_n)
        else $error("output enable not followed");
    data_hold_a: assert property ((!o_fall_through_mode && i_read_en_n) [*8] |-> $stable(o_read_data))
        else $error("output changed without read");
    full_cause_a: assert property (!o_fall_through_mode && $fell(o_full_flag_n) |-> wen_age_r < 5'd12)
        else $error("full without write");
    fill_cause_a: assert property (!o_fall_through_mode && rst_age_r > 5'd3 && $rose(o_empty_flag_n)
        |-> wen_age_r < 5'd12) else $error("not empty without write");
    drain_cause_a: assert property (!o_fall_through_mode && $fell(o_empty_flag_n)
        |-> ren_age_r < 5'd12) else $error("empty without read");
    ready_cause_a: assert property (o_fall_through_mode && rst_age_r > 5'd3 && $rose(o_empty_flag_n)
        |-> ren_age_r < 5'd12) else $error("output ready lost without true read");
    full_flags_a: assert property ((!o_fall_through_mode && !o_full_flag_n) [*3]
        |-> !o_half_full_n && !o_almost_full_n) else $error("full without half and almost full");
    cover property (!o_fall_through_mode && !o_full_flag_n);
    cover property (o_fall_through_mode && !o_empty_flag_n);
    cover property (!i_offset_load_n && !i_read_en_n);
endmodule
bind dcsf_top dcsf_top_monitor #(.MEM_DEPTH(MEM_DEPTH), .OFFSET_DEFAULT(OFFSET_DEFAULT)) u_mon (.*);
`default_nettype wire

// ===== tb/dcsf_partner.sv
// Producer and consumer model that works the FIFO strobe pins.
`timescale 1ns/1ps
`default_nettype none
module dcsf_partner
    import dcsf_pkg::*;
(
    input wire logic i_clk,
    output logic o_write_strobe,
    output logic o_write_en_n,
    output logic [dcsf_pkg::DATA_W-1:0] o_write_data,
    output logic o_read_strobe,
    output logic o_read_en_n,
    output logic o_offset_load_n,
    output logic o_read_done
);
    initial begin
        o_write_strobe = 1'b0;
        o_write_en_n = 1'b1;
        o_write_data = '0;
        o_read_strobe = 1'b0;
        o_read_en_n = 1'b1;
        o_offset_load_n = 1'b1;
        o_read_done = 1'b0;
    end
    // Each strobe level lasts three cycles, above the two-cycle minimum.
    task automatic strobe(input logic is_wr, input int slow);
        repeat (slow + 1) @(posedge i_clk);
        o_write_strobe <= is_wr;
        o_read_strobe <= !is_wr;
        repeat (3) @(posedge i_clk);
        o_write_strobe <= 1'b0;
        o_read_strobe <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic write_word(input logic [DATA_W-1:0] data, input logic en_n, input logic ld_n,
                              input int slow);
        @(posedge i_clk);
        o_write_data <= data;
        o_write_en_n <= en_n;
        o_offset_load_n <= ld_n;
        strobe(1'b1, slow);
        o_write_en_n <= 1'b1;
        o_offset_load_n <= 1'b1;
        // Released data shows the inverse so a stale word cannot pass for a new one.
        o_write_data <= ~data;
    endtask
    task automatic read_word(input logic en_n, input logic ld_n, input int slow);
        @(posedge i_clk);
        o_read_en_n <= en_n;
        o_offset_load_n <= ld_n;
        strobe(1'b0, slow);
        o_read_en_n <= 1'b1;
        o_offset_load_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_read_done <= 1'b1;
        @(posedge i_clk);
        o_read_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the strobe-driven FIFO.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
    end \
end
module tb;
    import dcsf_pkg::*;
    localparam int DEPTH = 8;
    logic clk, rstn, oe_n, wstb, wen_n, rstb, ren_n, ld_n, rd_done;
    logic rdata_oe, full_n, empty_n, half_n, afull_n, aempty_n, ft_mode;
    logic [2:0] straps;
    logic [DATA_W-1:0] wdata, rdata, exp_v;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] words[DEPTH+2];
    int mismatches = 0;
    int check_count = 0;
    int seed;
    dcsf_top #(.MEM_DEPTH(DEPTH)) uut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_write_strobe(wstb), .i_write_en_n(wen_n),
        .i_write_data(wdata), .i_read_strobe(rstb), .i_read_en_n(ren_n), .i_out_en_n(oe_n),
        .i_offset_load_n(ld_n), .i_first_load_n(straps[2]), .i_read_chain_in(straps[1]),
        .i_write_chain_in(straps[0]), .o_read_data(rdata), .o_read_data_oe(rdata_oe),
        .o_full_flag_n(full_n), .o_empty_flag_n(empty_n), .o_half_full_n(half_n),
        .o_almost_full_n(afull_n), .o_almost_empty_n(aempty_n), .o_fall_through_mode(ft_mode));
    dcsf_partner u_partner (.i_clk(clk), .o_write_strobe(wstb), .o_write_en_n(wen_n),
        .o_write_data(wdata), .o_read_strobe(rstb), .o_read_en_n(ren_n),
        .o_offset_load_n(ld_n), .o_read_done(rd_done));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        rstn <= 1'b0;
        straps <= s;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (rd_done === 1'b1) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            `CHK(rdata, exp_v)
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        rstn = 1'b0;
        oe_n = 1'b1;
        straps = 3'h0;
        seed = $urandom(32'ha93f8828);
        do_reset(3'h0);
        `CHK({full_n, empty_n, half_n, afull_n, aempty_n}, 5'b10100)
        `CHK({ft_mode, rdata_oe, rdata}, {2'b00, OUT_RESET})
        oe_n <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(rdata_oe, 1'b1)
        exp_q.push_back(OUT_RESET);
        u_partner.read_word(1'b1, 1'b1, 0);
        $display("test reset_values done");
        for (int i = 0; i < DEPTH + 1; i++) begin
            words[i] = DATA_W'($urandom);
            u_partner.write_word(words[i], 1'b0, 1'b1, $urandom_range(0, 2));
            if (i < DEPTH) exp_q.push_back(words[i]);
        end
        `CHK({full_n, half_n, afull_n}, 3'b000)
        for (int i = 0; i < DEPTH; i++) begin
            u_partner.read_word(1'b0, 1'b1, $urandom_range(0, 2));
            if (i == 0) begin
                // The flag is refreshed only by a write strobe edge, so give it an idle one.
                u_partner.write_word(DATA_W'($urandom), 1'b1, 1'b1, 0);
                `CHK(full_n, 1'b1)
            end
        end
        exp_q.push_back(words[DEPTH-1]);
        u_partner.read_word(1'b0, 1'b1, 0);
        u_partner.write_word(DATA_W'($urandom), 1'b1, 1'b1, 0);
        `CHK(empty_n, 1'b0)
        $display("test standard_fill done");
        do_reset(3'h0);
        for (int i = 0; i < 3; i++) words[i] = {6'h00, OFS_W'($urandom)};
        u_partner.write_word(words[0], 1'b0, 1'b0, 0);
        u_partner.write_word(~words[0], 1'b1, 1'b1, 0);
        u_partner.write_word(words[1], 1'b0, 1'b0, 1);
        u_partner.write_word(~words[1], 1'b1, 1'b0, 0);
        u_partner.write_word(words[2], 1'b0, 1'b0, 2);
        `CHK(empty_n, 1'b0)
        exp_q.push_back(words[2]);
        exp_q.push_back(words[1]);
        exp_q.push_back(words[2]);
        repeat (3) u_partner.read_word(1'b0, 1'b0, 0);
        do_reset(3'h0);
        repeat (2) exp_q.push_back({6'h00, DEF_OFFSET});
        repeat (2) u_partner.read_word(1'b0, 1'b0, 1);
        $display("test offsets done");
        do_reset(STRAP_FALL_THROUGH);
        `CHK({ft_mode, empty_n}, 2'b11)
        words[0] = DATA_W'($urandom);
        u_partner.write_word(words[0], 1'b0, 1'b1, 0);
        exp_q.push_back(OUT_RESET);
        exp_q.push_back(OUT_RESET);
        exp_q.push_back(words[0]);
        repeat (3) u_partner.read_word(1'b1, 1'b1, 0);
        `CHK(empty_n, 1'b0)
        for (int i = 1; i < DEPTH + 2; i++) begin
            words[i] = DATA_W'($urandom);
            u_partner.write_word(words[i], 1'b0, 1'b1, $urandom_range(0, 2));
            if (i == DEPTH - 1) `CHK(full_n, 1'b0)
        end
        `CHK(full_n, 1'b1)
        for (int i = 1; i <= DEPTH; i++) begin
            exp_q.push_back(words[i]);
            u_partner.read_word(1'b0, 1'b1, $urandom_range(0, 2));
            if (i == 1) begin
                u_partner.write_word(DATA_W'($urandom), 1'b1, 1'b1, 0);
                `CHK(full_n, 1'b0)
            end
        end
        `CHK(empty_n, 1'b0)
        repeat (2) exp_q.push_back(words[DEPTH]);
        u_partner.read_word(1'b0, 1'b1, 0);
        `CHK(empty_n, 1'b1)
        u_partner.read_word(1'b0, 1'b0, 0);
        $display("test fall_through done");
        repeat (2) @(posedge clk);
        stop_test();
    end
endmodule
`default_nettype wire
